// ### core/adcic_clkdiv.v
`timescale 1ns/1ns
`default_nettype none
`include "adcic_defs.vh"
// Converter clock tick: one pulse per 2^sel system clocks.
module adcic_clkdiv (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire run_i,
  input wire [2:0] div_sel_i,
  output reg tick_o
);
  reg [6:0] cnt;
  wire [6:0] limit;
  assign limit = (7'h01 << div_sel_i) - 7'h01;
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 7'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      // Restart so each conversion begins phase-aligned
      cnt <= 7'h00;
      tick_o <= 1'b0;
    end else if (cnt >= limit) begin
      cnt <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      tick_o <= 1'b0;
    end
  end
endmodule // adcic_clkdiv
`default_nettype wire

// ### core/adcic_ctrl.v
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "adcic_defs.vh"
module adcic_ctrl (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [15:0] pin_out_i,
  input wire [15:0] pin_oe_i,
  input wire [15:0] pin_pull_i,
  output wire [15:0] pin_out_o,
  output wire [15:0] pin_oe_o,
  output wire [15:0] pin_pull_o,
  output wire [15:0] pin_analog_o,
  output wire [15:0] chan_connect_o,
  output wire [2:0] input_sel_o,
  output wire [1:0] input_scale_o,
  output wire [1:0] ref_sel_o,
  output wire bandgap_enable_o,
  output wire bandgap_hiz_o,
  output wire amp_enable_o,
  output wire amp_input_sel_o,
  output wire [1:0] amp_gain_o,
  output wire conv_power_o,
  output wire sample_o,
  output wire convert_o,
  output reg conv_done_o,
  input wire comp_i,
  output wire irq_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ARM = 2'h1;
  localparam ST_RUN = 2'h2;

  reg [7:0] ctrl0;
  reg [7:0] ctrl1;
  reg [7:0] ctrl2;
  reg [7:0] bgr;
  reg [15:0] pin_function_select;
  reg conv_busy_flag;
  reg converter_interrupt_flag;
  reg converter_interrupt_enable;
  reg global_interrupt_enable;
  reg [11:0] result;
  reg [11:0] sar;
  reg [4:0] cyc;
  reg [1:0] state;
  reg [1:0] next_state;
  reg comp_s1;
  reg comp_s2;
  reg [2:0] asel;
  reg [1:0] scale;
  wire start_bit;
  wire power_en;
  wire [3:0] channel_select;
  wire [3:0] input_source_select;
  wire tick;
  wire running;
  wire done_evt;
  wire sar_bit_evt;
  wire [3:0] bit_idx;
  wire flag_wr;

  assign start_bit = ctrl0[`ADCIC_C0_START];
  assign power_en = ctrl0[`ADCIC_C0_PWR];
  assign channel_select = ctrl0[`ADCIC_C0_CH_HI:`ADCIC_C0_CH_LO];
  assign input_source_select = ctrl1[`ADCIC_C1_INS_HI:`ADCIC_C1_INS_LO];

  // Comparator is analog, asynchronous to this clock
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
    end else begin
      comp_s1 <= comp_i;
      comp_s2 <= comp_s1;
    end
  end

  adcic_clkdiv u_div (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .run_i(running),
    .div_sel_i(ctrl1[`ADCIC_C1_DIV_HI:`ADCIC_C1_DIV_LO]),
    .tick_o(tick)
  );

  assign running = (state == ST_RUN);
  assign done_evt = running && tick && (cyc == `ADCIC_TOTAL_CYC - 5'h01);
  assign sar_bit_evt = running && tick && (cyc >= `ADCIC_SAMPLE_CYC);
  assign bit_idx = 4'hf - cyc[3:0];

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_bit && power_en)
          next_state = ST_ARM;
      end
      ST_ARM: begin
        if (!power_en)
          next_state = ST_IDLE;
        else if (!start_bit)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!power_en)
          next_state = ST_IDLE;
        else if (start_bit)
          next_state = ST_ARM;
        else if (done_evt)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      cyc <= 5'h00;
      sar <= 12'h000;
      result <= 12'h000;
      conv_busy_flag <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      state <= next_state;
      conv_done_o <= done_evt;
      conv_busy_flag <= (next_state == ST_RUN);
      if (!running) begin
        cyc <= 5'h00;
        sar <= 12'h000;
      end else if (tick) begin
        cyc <= cyc + 5'h01;
        if (sar_bit_evt)
          sar[bit_idx] <= comp_s2;
      end
      if (done_evt)
        result <= {sar[11:1], comp_s2};
    end
  end

  // phase outputs
  // Power gate also covers the cycle before the sequencer drops to idle
  assign sample_o = running && power_en && (cyc < `ADCIC_SAMPLE_CYC);
  assign convert_o = running && power_en && (cyc >= `ADCIC_SAMPLE_CYC);
  assign conv_power_o = power_en;

  assign flag_wr = wr_i && (addr_i == `ADCIC_OFF_IRQ);
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converter_interrupt_flag <= 1'b0;
      converter_interrupt_enable <= 1'b0;
      global_interrupt_enable <= 1'b0;
    end else begin
      if (flag_wr) begin
        converter_interrupt_enable <= wdata_i[`ADCIC_IRQ_EN];
        global_interrupt_enable <= wdata_i[`ADCIC_IRQ_GIE];
      end
      // Set beats a clear in the same cycle
      if (done_evt)
        converter_interrupt_flag <= 1'b1;
      else if (flag_wr)
        converter_interrupt_flag <= wdata_i[`ADCIC_IRQ_FLAG];
    end
  end
  assign irq_o = converter_interrupt_flag && converter_interrupt_enable
    && global_interrupt_enable;

  // Register writes
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl0 <= `ADCIC_RST_BYTE;
      ctrl1 <= `ADCIC_RST_BYTE;
      ctrl2 <= `ADCIC_RST_BYTE;
      bgr <= `ADCIC_RST_BYTE;
      pin_function_select <= `ADCIC_RST_PINSEL;
    end else if (wr_i) begin
      case (addr_i)
        `ADCIC_OFF_CTRL0: ctrl0 <= wdata_i;
        `ADCIC_OFF_CTRL1: ctrl1 <= wdata_i;
        `ADCIC_OFF_CTRL2: ctrl2 <= wdata_i & `ADCIC_C2_MASK;
        `ADCIC_OFF_BGR: bgr <= {7'h00, wdata_i[`ADCIC_BGR_EN]};
        `ADCIC_OFF_RESH: pin_function_select[15:8] <= wdata_i;
        `ADCIC_OFF_PINSEL: pin_function_select[7:0] <= wdata_i;
        default: ;
      endcase
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ADCIC_OFF_CTRL0: rdata_o <= {ctrl0[7], conv_busy_flag, ctrl0[5:0]};
        `ADCIC_OFF_CTRL1: rdata_o <= ctrl1;
        `ADCIC_OFF_CTRL2: rdata_o <= ctrl2;
        `ADCIC_OFF_BGR: rdata_o <= {7'h00, bgr[`ADCIC_BGR_EN]};
        `ADCIC_OFF_RESH: rdata_o <= ctrl0[`ADCIC_C0_FMT] ?
          {4'h0, result[11:8]} : result[11:4];
        `ADCIC_OFF_RESL: rdata_o <= ctrl0[`ADCIC_C0_FMT] ?
          result[7:0] : {result[3:0], 4'h0};
        `ADCIC_OFF_IRQ: rdata_o <= {5'h00, global_interrupt_enable,
          converter_interrupt_enable, converter_interrupt_flag};
        `ADCIC_OFF_PINSEL: rdata_o <= pin_function_select[7:0];
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  assign ref_sel_o = ctrl2[`ADCIC_C2_REF_HI] ? `ADCIC_REF_AMP :
    (ctrl2[`ADCIC_C2_REF_LO] ? `ADCIC_REF_PIN : `ADCIC_REF_VDD);
  assign bandgap_enable_o = bgr[`ADCIC_BGR_EN];
  assign bandgap_hiz_o = ~bgr[`ADCIC_BGR_EN];
  assign amp_enable_o = ctrl2[`ADCIC_C2_AMPEN];
  assign amp_input_sel_o = ctrl2[`ADCIC_C2_AMPIS];
  assign amp_gain_o = ctrl2[`ADCIC_C2_GAIN_HI:`ADCIC_C2_GAIN_LO];

  always @* begin
    asel = `ADCIC_ASEL_EXT;
    scale = 2'h0;
    case (input_source_select)
      `ADCIC_SRC_VDD: asel = `ADCIC_ASEL_VDD;
      `ADCIC_SRC_VDD2: begin
        asel = `ADCIC_ASEL_VDD;
        scale = 2'h1;
      end
      `ADCIC_SRC_VDD4: begin
        asel = `ADCIC_ASEL_VDD;
        scale = 2'h2;
      end
      `ADCIC_SRC_AMP: asel = `ADCIC_ASEL_AMP;
      `ADCIC_SRC_AMP2: begin
        asel = `ADCIC_ASEL_AMP;
        scale = 2'h1;
      end
      `ADCIC_SRC_AMP4: begin
        asel = `ADCIC_ASEL_AMP;
        scale = 2'h2;
      end
      4'h8, 4'h9, 4'ha, 4'hb: asel = `ADCIC_ASEL_GND;
      default: asel = `ADCIC_ASEL_EXT;
    endcase
  end
  assign input_sel_o = power_en ? asel : `ADCIC_ASEL_GND;
  assign input_scale_o = scale;

  // Per-pin function override
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_pin
      assign pin_out_o[g] = pin_function_select[g] ? 1'b0 : pin_out_i[g];
      assign pin_oe_o[g] = pin_function_select[g] ? 1'b0 : pin_oe_i[g];
      assign pin_pull_o[g] = pin_function_select[g] ? 1'b0 : pin_pull_i[g];
      assign pin_analog_o[g] = pin_function_select[g];
      assign chan_connect_o[g] = power_en && (asel == `ADCIC_ASEL_EXT)
        && pin_function_select[g] && ({28'h0000000, channel_select} == g);
    end
  endgenerate
endmodule // adcic_ctrl
`default_nettype wire

// ### core/adcic_defs.vh
`ifndef ADCIC_DEFS_VH
`define ADCIC_DEFS_VH
// Register offsets
`define ADCIC_OFF_CTRL0 3'h0
`define ADCIC_OFF_CTRL1 3'h1
`define ADCIC_OFF_CTRL2 3'h2
`define ADCIC_OFF_BGR 3'h3
`define ADCIC_OFF_RESH 3'h4
`define ADCIC_OFF_RESL 3'h5
`define ADCIC_OFF_IRQ 3'h6
`define ADCIC_OFF_PINSEL 3'h7
// Control-first fields
`define ADCIC_C0_START 7
`define ADCIC_C0_BUSY 6
`define ADCIC_C0_PWR 5
`define ADCIC_C0_FMT 4
`define ADCIC_C0_CH_HI 3
`define ADCIC_C0_CH_LO 0
// Control-second fields
`define ADCIC_C1_INS_HI 7
`define ADCIC_C1_INS_LO 4
`define ADCIC_C1_DIV_HI 2
`define ADCIC_C1_DIV_LO 0
// Control-third fields
`define ADCIC_C2_AMPEN 7
`define ADCIC_C2_AMPIS 4
`define ADCIC_C2_REF_HI 3
`define ADCIC_C2_REF_LO 2
`define ADCIC_C2_GAIN_HI 1
`define ADCIC_C2_GAIN_LO 0
`define ADCIC_C2_MASK 8'h9f
// Bandgap control
`define ADCIC_BGR_EN 0
// Interrupt register fields
`define ADCIC_IRQ_FLAG 0
`define ADCIC_IRQ_EN 1
`define ADCIC_IRQ_GIE 2
// Reset values
`define ADCIC_RST_BYTE 8'h00
`define ADCIC_RST_PINSEL 16'h0000
// Timing, in converter clock cycles
`define ADCIC_SAMPLE_CYC 5'h04
`define ADCIC_TOTAL_CYC 5'h10
// Input source codes
`define ADCIC_SRC_VDD 4'h1
`define ADCIC_SRC_VDD2 4'h2
`define ADCIC_SRC_VDD4 4'h3
`define ADCIC_SRC_AMP 4'h5
`define ADCIC_SRC_AMP2 4'h6
`define ADCIC_SRC_AMP4 4'h7
// Analog selector codes
`define ADCIC_ASEL_EXT 3'h0
`define ADCIC_ASEL_VDD 3'h1
`define ADCIC_ASEL_AMP 3'h2
`define ADCIC_ASEL_GND 3'h3
`define ADCIC_REF_VDD 2'h0
`define ADCIC_REF_PIN 2'h1
`define ADCIC_REF_AMP 2'h2
`endif

// ### dv/adcic_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcic_defs.vh"
module adcic_analog_model (
  input wire logic core_clk_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] chan_connect_i,
  input wire logic [2:0] input_sel_i,
  input wire logic conv_power_i,
  output logic comp_o
);
  logic flip = 1'b0;
  always @(posedge core_clk_i) flip <= ~flip;
  // Unpowered output wanders; powered high means full scale
  always_comb
    if (!conv_power_i) comp_o = flip;
    else if (input_sel_i == `ADCIC_ASEL_EXT) comp_o = |(level_i & chan_connect_i);
    else comp_o = (input_sel_i == `ADCIC_ASEL_VDD);
endmodule // adcic_analog_model
`default_nettype wire

// ### dv/adcic_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcic_defs.vh"
module adcic_ctrl_properties (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [15:0] pin_out_i,
  input wire logic [15:0] pin_oe_i,
  input wire logic [15:0] pin_pull_i,
  input wire logic [15:0] pin_out_o,
  input wire logic [15:0] pin_oe_o,
  input wire logic [15:0] pin_pull_o,
  input wire logic [15:0] pin_analog_o,
  input wire logic [15:0] chan_connect_o,
  input wire logic [2:0] input_sel_o,
  input wire logic bandgap_enable_o,
  input wire logic bandgap_hiz_o,
  input wire logic conv_power_o,
  input wire logic sample_o,
  input wire logic convert_o,
  input wire logic conv_done_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // A rewrite of the control word may legally cut sampling short
  sequence seq_sample;
    sample_o [*4];
  endsequence
  sequence seq_abort;
    ##[0:3] ((wr_i && addr_i == `ADCIC_OFF_CTRL0) || !conv_power_o);
  endsequence
  chk_pin_gate: assert property (
    pin_oe_o == (pin_oe_i & ~pin_analog_o) && pin_out_o == (pin_out_i & ~pin_analog_o))
    else $error("pin drive not gated");
  chk_pull_detach: assert property (
    pin_pull_o == (pin_pull_i & ~pin_analog_o)) else $error("pull not detached");
  chk_bg_hiz: assert property (
    bandgap_hiz_o != bandgap_enable_o) else $error("bandgap hiz wrong");
  chk_int_disconnect: assert property (
    input_sel_o != `ADCIC_ASEL_EXT |-> chan_connect_o == 16'h0000)
    else $error("channel left connected");
  chk_power_off: assert property (
    !conv_power_o |-> input_sel_o == `ADCIC_ASEL_GND && !sample_o && !convert_o)
    else $error("converter active while off");
  chk_sample_len: assert property (
    $rose(sample_o) |-> seq_sample or seq_abort) else $error("sampling too short");
  chk_samp_conv: assert property (
    $fell(sample_o) && conv_power_o && !$past(wr_i) |-> convert_o)
    else $error("no convert after sample");
  chk_done_pulse: assert property (
    conv_done_o |=> !conv_done_o && !convert_o) else $error("done not one pulse");
  chk_irq_cause: assert property (
    $rose(irq_o) |-> conv_done_o || $past(conv_done_o) || $past(wr_i))
    else $error("irq without cause");
  chk_read_idle: assert property (
    !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data outside slot");
  chk_bgr_upper: assert property (
    $past(rd_i) && $past(addr_i) == `ADCIC_OFF_BGR |-> rdata_o[7:1] == 7'h00)
    else $error("bandgap upper bits set");
  chk_busy_read: assert property (
    $past(rd_i) && $past(addr_i) == `ADCIC_OFF_CTRL0 && ($past(sample_o) || $past(convert_o))
    |-> rdata_o[6])
    else $error("busy low in conversion");
endmodule // adcic_ctrl_properties
bind adcic_ctrl adcic_ctrl_properties i_adcic_ctrl_properties (.core_clk_i, .rst_b_i, .addr_i,
  .wr_i, .rd_i, .rdata_o, .pin_out_i, .pin_oe_i, .pin_pull_i, .pin_out_o, .pin_oe_o,
  .pin_pull_o, .pin_analog_o, .chan_connect_o, .input_sel_o, .bandgap_enable_o,
  .bandgap_hiz_o, .conv_power_o, .sample_o, .convert_o, .conv_done_o, .irq_o);
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcic_defs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
  logic core_clk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0;
  logic [2:0] addr_i = 0, es;
  logic [7:0] wdata_i = 0, rdata_o;
  logic [15:0] pin_out_i = 16'hffff, pin_oe_i = 16'hffff, pin_pull_i = 16'hffff;
  logic [15:0] level = 16'h0001;
  wire [15:0] pin_out_o, pin_oe_o, pin_pull_o, pin_analog_o, chan_connect_o;
  wire [2:0] input_sel_o;
  wire [1:0] input_scale_o, ref_sel_o, amp_gain_o;
  wire bandgap_enable_o, bandgap_hiz_o, conv_power_o, sample_o, convert_o, conv_done_o;
  wire comp_i, irq_o, amp_enable_o, amp_input_sel_o;
  int fail_count = 0, checks = 0, cyc = 0, k;
  adcic_ctrl i_adcic_ctrl (.core_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pin_out_i, .pin_oe_i, .pin_pull_i, .pin_out_o, .pin_oe_o, .pin_pull_o, .pin_analog_o,
    .chan_connect_o, .input_sel_o, .input_scale_o, .ref_sel_o, .bandgap_enable_o,
    .bandgap_hiz_o, .amp_enable_o, .amp_input_sel_o, .amp_gain_o, .conv_power_o,
    .sample_o, .convert_o, .conv_done_o, .comp_i, .irq_o);
  adcic_analog_model i_adcic_analog_model (.core_clk_i, .level_i(level),
    .chan_connect_i(chan_connect_o), .input_sel_i(input_sel_o), .conv_power_i(conv_power_o),
    .comp_o(comp_i));
  initial forever #2 core_clk_i = ~core_clk_i;
  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    // Idle edge keeps back-to-back strobes apart
    @(posedge core_clk_i);
  endtask
  task automatic peek(input logic [2:0] a, output logic [7:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    peek(a, v);
    `CHK("rdata", e, v)
  endtask
  task automatic conv(input logic [7:0] c0, input logic [7:0] hi, input logic [7:0] lo,
    input int d);
    logic [7:0] v;
    int polls;
    // Start bit pulsed high then low
    wr(`ADCIC_OFF_CTRL0, c0 | 8'h80);
    wr(`ADCIC_OFF_CTRL0, c0);
    peek(`ADCIC_OFF_CTRL0, v);
    polls = 1;
    `CHK("busy", 1'b1, v[6])
    repeat (3000) if (v[6] === 1'b1) begin
      peek(`ADCIC_OFF_CTRL0, v);
      polls++;
    end
    `CHK("busy_end", 1'b0, v[6])
    // Two-cycle polls over 16 ticks of 2^d clocks, plus the first and the idle read
    `CHK("length", 8 * (1 << d) + 2, polls)
    rd(`ADCIC_OFF_RESH, hi);
    rd(`ADCIC_OFF_RESL, lo);
    $display("conversion test done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    for (k = 0; k < 8; k++) rd(k[2:0], 8'h00);
    wr(`ADCIC_OFF_BGR, 8'hff);
    rd(`ADCIC_OFF_BGR, 8'h01);
    `CHK("bandgap", 2'b10, {bandgap_enable_o, bandgap_hiz_o})
    wr(`ADCIC_OFF_PINSEL, 8'h01);
    #1 `CHK("oe", 16'hfffe, pin_oe_o)
    `CHK("pull", 16'hfffe, pin_pull_o)
    `CHK("out", 16'hfffe, pin_out_o)
    @(posedge core_clk_i);
    $display("register and pin test done");
    wr(`ADCIC_OFF_CTRL0, 8'h20);
    for (k = 0; k < 16; k++) begin
      wr(`ADCIC_OFF_CTRL1, {k[3:0], 4'h0});
      es = (k[1:0] == 0 && !k[3]) || k[3:2] == 2'b11 ? 3'h0 : (k[3] ? 3'h3 : (k[2] ? 3'h2 : 3'h1));
      #1 `CHK("source", es, input_sel_o)
      `CHK("connect", es == 0 ? 16'h0001 : 16'h0000, chan_connect_o)
      if (es == 1 || es == 2) `CHK("scale", k[1:0] - 2'h1, input_scale_o)
      @(posedge core_clk_i);
    end
    for (k = 0; k < 4; k++) begin
      // Amplifier enabled whenever it is the reference
      wr(`ADCIC_OFF_CTRL2, {k[1], 2'h0, k[0], k[1:0], k[1:0]});
      #1 `CHK("ref", k[1] ? 2'h2 : {1'b0, k[0]}, ref_sel_o)
      `CHK("amp", {k[1], k[0], k[1:0]}, {amp_enable_o, amp_input_sel_o, amp_gain_o})
      @(posedge core_clk_i);
    end
    $display("selection test done");
    wr(`ADCIC_OFF_CTRL1, 8'h00);
    wr(`ADCIC_OFF_IRQ, 8'h06);
    conv(8'h20, 8'hff, 8'hf0, 0);
    `CHK("irq", 1'b1, irq_o)
    wr(`ADCIC_OFF_IRQ, 8'h06);
    #1 `CHK("irq_clr", 1'b0, irq_o)
    @(posedge core_clk_i);
    wr(`ADCIC_OFF_CTRL1, 8'h03);
    conv(8'h30, 8'h0f, 8'hff, 3);
    level <= 16'h0000;
    conv(8'h30, 8'h00, 8'h00, 3);
    wr(`ADCIC_OFF_CTRL1, 8'h10);
    conv(8'h30, 8'h0f, 8'hff, 0);
    wr(`ADCIC_OFF_CTRL1, 8'h80);
    conv(8'h30, 8'h00, 8'h00, 0);
    wr(`ADCIC_OFF_CTRL0, 8'h80);
    wr(`ADCIC_OFF_CTRL0, 8'h00);
    #1 `CHK("off_source", 3'h3, input_sel_o)
    @(posedge core_clk_i);
    rd(`ADCIC_OFF_CTRL0, 8'h00);
    $display("power test done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
